// [rtl/swm_ctrl.sv]
// Purpose: wire mode control, start detector, shift register, counter and pin drive
// Assumes: pins are sampled on mclk; link clock far slower than mclk
// Notes: all outputs come from the state register, one cycle behind their cause
module swm_ctrl
  import swm_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              wb_cyc,
  input  wire logic              wb_stb,
  input  wire logic              wb_we,
  input  wire logic [ADDR_W-1:0] wb_adr,
  input  wire logic [3:0]        wb_sel,
  input  wire logic [31:0]       wb_dat_w,
  output logic      [31:0]       wb_dat_r,
  output logic                   wb_ack,
  input  wire logic [NPIN-1:0]   pin_in,
  output logic      [NPIN-1:0]   pin_out,
  output logic      [NPIN-1:0]   pin_oe,
  output logic      [NPIN-1:0]   pin_pullup,
  output logic                   irq
);

  typedef struct packed {
    logic            sie;
    logic            oie;
    swm_wm_t         wm;
    logic            ext;
    logic            sif;
    logic            oif;
    logic [3:0]      cnt;
    logic [7:0]      data;
    logic            out_latch;
    logic [NPIN-1:0] port;
    logic [NPIN-1:0] dir;
    logic [1:0]      irq_stat;
    logic [1:0]      irq_mask;
    logic            gie;
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [NPIN-1:0] prev;
    logic            ack;
    logic [7:0]      rdat;
    logic            irq;
    logic [NPIN-1:0] pin_o;
    logic [NPIN-1:0] pin_e;
    logic [NPIN-1:0] pin_p;
  } swm_state_t;

  swm_state_t s;
  swm_state_t n;
  logic [1:0] rst_q;
  logic       rst_i_n;
  logic       req;
  logic       wr;
  logic       rd;
  logic       sck_rise;
  logic       sck_fall;
  logic       sda_fall;
  logic       two;
  logic       start_evt;
  logic       shift;
  logic       count;
  logic       ovf;
  logic       scl_hold;
  logic [7:0] wd;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_i_n = rst_q[1];

  always_comb begin
    n         = s;
    wd        = wb_dat_w[7:0];
    req       = wb_cyc && wb_stb && !s.ack;
    wr        = req && wb_we && wb_sel[0];
    rd        = req && !wb_we;
    sck_rise  = s.sync2[PIN_SCL] && !s.prev[PIN_SCL];
    sck_fall  = !s.sync2[PIN_SCL] && s.prev[PIN_SCL];
    sda_fall  = !s.sync2[PIN_SDA] && s.prev[PIN_SDA];
    two       = s.wm[1];
    // start: in two-wire modes data falls while clock stays high; in other modes any clock edge
    start_evt = two ? (sda_fall && s.sync2[PIN_SCL] && s.prev[PIN_SCL])
                    : (sck_rise || sck_fall);
    // inputs clock the shifter in every wire mode
    shift     = (s.ext && sck_rise) || (wr && wb_adr == OFF_CTRL && wd[CTL_CLK]);
    count     = (s.ext && (sck_rise || sck_fall))
             || (wr && wb_adr == OFF_CTRL && wd[CTL_CLK]);
    ovf       = count && s.cnt == CNT_MAX;
    scl_hold  = (two && s.sif)
             || (s.wm == SWM_WM_TWO_HOLD && s.oif);

    n.sync1 = pin_in;
    n.sync2 = s.sync1;
    n.prev  = s.sync2;
    n.ack   = req;
    n.rdat  = REG_RST;

    if (shift) begin
      n.data = {s.data[6:0], s.sync2[PIN_SDA]};
    end
    if (count) begin
      n.cnt = s.cnt + 4'h1;
    end
    // latch open in the first half of an external clock, always open otherwise
    if (!s.ext || !s.sync2[PIN_SCL]) begin
      n.out_latch = s.data[7];
    end

    if (rd && wb_adr == OFF_IRQ_STAT) begin
      n.irq_stat = 2'h0;
    end

    if (wr) begin
      case (wb_adr)
        OFF_CTRL: begin
          n.sie = wd[CTL_SIE];
          n.oie = wd[CTL_OIE];
          n.wm  = swm_wm_t'(wd[CTL_WM_HI:CTL_WM_LO]);
          n.ext = wd[CTL_EXT];
          if (wd[CTL_TC]) begin
            n.port[PIN_SCL] = !s.port[PIN_SCL];
          end
        end
        OFF_STAT: begin
          if (wd[STA_SIF]) begin
            n.sif = 1'b0;
          end
          if (wd[STA_OIF]) begin
            n.oif = 1'b0;
          end
          n.cnt = wd[3:0];
        end
        OFF_DATA: begin
          n.data = wd;
        end
        OFF_PORT: begin
          n.port = wd[NPIN-1:0];
        end
        OFF_DIR: begin
          n.dir = wd[NPIN-1:0];
        end
        OFF_IRQ_MASK: begin
          n.irq_mask = wd[1:0];
        end
        OFF_GIE: begin
          n.gie = wd[0];
        end
        default: begin
        end
      endcase
    end

    // hardware set wins over a clear in the same cycle
    if (start_evt) begin
      n.sif                = 1'b1;
      n.irq_stat[IRQ_START] = 1'b1;
    end
    if (ovf) begin
      n.oif              = 1'b1;
      n.irq_stat[IRQ_OVF] = 1'b1;
    end

    if (rd) begin
      case (wb_adr)
        OFF_CTRL:     n.rdat = {s.sie, s.oie, s.wm, s.ext, 3'h0};
        OFF_STAT:     n.rdat = {s.sif, s.oif, 2'h0, s.cnt};
        OFF_DATA:     n.rdat = s.data;
        OFF_PORT:     n.rdat = {5'h0, s.port};
        OFF_DIR:      n.rdat = {5'h0, s.dir};
        OFF_IRQ_STAT: n.rdat = {6'h0, s.irq_stat};
        OFF_IRQ_MASK: n.rdat = {6'h0, s.irq_mask};
        OFF_GIE:      n.rdat = {7'h0, s.gie};
        default:      n.rdat = REG_RST;
      endcase
    end

    // pins default to plain port behaviour
    n.pin_o = s.port;
    n.pin_e = s.dir;
    n.pin_p = s.port & ~s.dir;
    case (s.wm)
      SWM_WM_OFF: begin
      end
      SWM_WM_THREE: begin
        n.pin_o[PIN_DO] = s.out_latch;
      end
      SWM_WM_TWO, SWM_WM_TWO_HOLD: begin
        n.pin_o[PIN_SDA] = 1'b0;
        n.pin_e[PIN_SDA] = s.dir[PIN_SDA]
                        && (!s.out_latch || !s.port[PIN_SDA]);
        n.pin_o[PIN_SCL] = 1'b0;
        n.pin_e[PIN_SCL] = s.dir[PIN_SCL]
                        && (!s.port[PIN_SCL] || scl_hold);
        n.pin_p[PIN_SDA] = 1'b0;
        n.pin_p[PIN_SCL] = 1'b0;
      end
      default: begin
      end
    endcase

    n.irq = (|(n.irq_stat & n.irq_mask))
         || (n.gie && ((n.sif && n.sie)
                    || (n.oif && n.oie)));
  end

  always_ff @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      s <= '0;
      // idle lines read high: no false clock edge after reset
      s.sync1 <= '1;
      s.sync2 <= '1;
      s.prev  <= '1;
    end else if (clk_en) begin
      s <= n;
    end
  end

  assign wb_dat_r   = {24'h0, s.rdat};
  assign wb_ack     = s.ack;
  assign pin_out    = s.pin_o;
  assign pin_oe     = s.pin_e;
  assign pin_pullup = s.pin_p;
  assign irq        = s.irq;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_i_n);

  sequence start_seen;
    clk_en && two && start_evt && !wr;
  endsequence

  sequence quiet_step;
    clk_en && !wr;
  endsequence

  sequence ovf_seen;
    clk_en && s.wm == SWM_WM_TWO_HOLD && ovf && !wr;
  endsequence

  start_irq_a: assert property (
    clk_en && start_evt && s.sie && s.gie && !wr |=> irq)
    else $error("start event with enables set did not raise irq");

  ovf_irq_a: assert property (
    clk_en && ovf && s.oie && s.gie && !wr |=> irq)
    else $error("overflow with enables set did not raise irq");

  input_shift_a: assert property (
    clk_en && s.ext && sck_rise && !wr |=> s.data[0] == $past(s.sync2[PIN_SDA]))
    else $error("external clock edge did not shift in the data pin");

  off_mode_a: assert property (
    clk_en && s.wm == SWM_WM_OFF |=> pin_out == $past(s.port) && pin_oe == $past(s.dir))
    else $error("pins not plain port in wire mode off");

  three_out_a: assert property (
    clk_en && s.wm == SWM_WM_THREE
      |=> pin_out[PIN_DO] == $past(s.out_latch) && pin_oe[PIN_DO] == $past(s.dir[PIN_DO]))
    else $error("data output pin not driven from latch in three-wire mode");

  three_pull_a: assert property (
    clk_en && s.wm == SWM_WM_THREE && !s.dir[PIN_DO] |=> pin_pullup[PIN_DO] == $past(s.port[PIN_DO]))
    else $error("input pull-up not taken from port bit");

  three_port_a: assert property (
    clk_en && s.wm == SWM_WM_THREE
      |=> pin_oe[PIN_SCL:PIN_SDA] == $past(s.dir[PIN_SCL:PIN_SDA]))
    else $error("three-wire mode changed clock or data-in pin drive");

  sda_pull_a: assert property (
    clk_en && two && s.dir[PIN_SDA] && !s.out_latch |=> pin_oe[PIN_SDA] && !pin_out[PIN_SDA])
    else $error("data line not pulled low for zero output");

  scl_release_a: assert property (
    clk_en && two && !s.dir[PIN_SCL] |=> !pin_oe[PIN_SCL])
    else $error("clock line driven with direction bit clear");

  start_hold_a: assert property (
    start_seen ##1 (quiet_step and s.dir[PIN_SCL]) |=> pin_oe[PIN_SCL] && !pin_out[PIN_SCL])
    else $error("clock not held low after start condition");

  ovf_hold_a: assert property (
    ovf_seen ##1 (quiet_step and s.dir[PIN_SCL]) |=> pin_oe[PIN_SCL])
    else $error("clock not held low after overflow in hold mode");

  two_pull_a: assert property (
    clk_en && two |=> pin_pullup[PIN_SCL:PIN_SDA] == 2'h0)
    else $error("pull-ups active in two-wire mode");

  sif_sticky_a: assert property (
    clk_en && s.sif && !(wr && wb_adr == OFF_STAT && wd[STA_SIF]) |=> s.sif)
    else $error("start flag cleared without a write of one");

  wrap_flag_a: assert property (
    clk_en && ovf && !wr |=> s.oif && s.cnt == 4'h0)
    else $error("counter wrap did not set overflow flag");

  latch_open_a: assert property (
    clk_en && !s.ext |=> s.out_latch == $past(s.data[7]))
    else $error("open output latch did not follow data msb");

  ack_pulse_a: assert property (
    clk_en && wb_ack |=> !wb_ack)
    else $error("bus acknowledge stood longer than one cycle");

  ack_answer_a: assert property (
    clk_en && wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("bus request not acknowledged in the next cycle");

  oif_sticky_a: assert property (
    clk_en && s.oif && !(wr && wb_adr == OFF_STAT && wd[STA_OIF]) |=> s.oif)
    else $error("overflow flag cleared without a write of one");

  scl_port_low_a: assert property (
    clk_en && two && s.dir[PIN_SCL] && !s.port[PIN_SCL] |=> pin_oe[PIN_SCL] && !pin_out[PIN_SCL])
    else $error("clock line not pulled low for zero port bit");

  sda_release_a: assert property (
    clk_en && two && s.dir[PIN_SDA] && s.out_latch && s.port[PIN_SDA] |=> !pin_oe[PIN_SDA])
    else $error("data line driven although both sources are one");

  plain_drive_a: assert property (
    clk_en && !two |=> pin_oe == $past(s.dir))
    else $error("pin drive not taken from direction bits outside two-wire mode");

  off_nostart_a: assert property (
    clk_en && s.wm == SWM_WM_OFF && !sck_rise && !sck_fall && !wr |=> s.sif == $past(s.sif))
    else $error("start flag changed in wire mode off without a clock edge");

  irq_quiet_a: assert property (
    clk_en && !wr && !s.gie && !start_evt && !ovf && !(|(s.irq_stat & s.irq_mask)) |=> !irq)
    else $error("interrupt raised with no enabled cause");

  count_step_a: assert property (
    clk_en && s.ext && sck_fall && !wr |=> s.cnt == $past(s.cnt) + 4'h1)
    else $error("external clock edge did not advance the counter");

  irq_clear_a: assert property (
    clk_en && rd && wb_adr == OFF_IRQ_STAT && !start_evt && !ovf |=> s.irq_stat == 2'h0)
    else $error("interrupt status not cleared by its read");

endmodule : swm_ctrl

// [shared/swm_pkg.sv]
// Purpose: constants and types for the serial wire mode controller
// Assumes: 32-bit classic Wishbone slave, registers in the low byte of each word
// Notes: register offsets are byte addresses
package swm_pkg;

  localparam int          ADDR_W       = 5;
  localparam int          NPIN         = 3;
  localparam logic [4:0]  OFF_CTRL     = 5'h00;
  localparam logic [4:0]  OFF_STAT     = 5'h04;
  localparam logic [4:0]  OFF_DATA     = 5'h08;
  localparam logic [4:0]  OFF_PORT     = 5'h0c;
  localparam logic [4:0]  OFF_DIR      = 5'h10;
  localparam logic [4:0]  OFF_IRQ_STAT = 5'h14;
  localparam logic [4:0]  OFF_IRQ_MASK = 5'h18;
  localparam logic [4:0]  OFF_GIE      = 5'h1c;
  localparam int          CTL_SIE      = 7;
  localparam int          CTL_OIE      = 6;
  localparam int          CTL_WM_HI    = 5;
  localparam int          CTL_WM_LO    = 4;
  localparam int          CTL_EXT      = 3;
  localparam int          CTL_CLK      = 1;
  localparam int          CTL_TC       = 0;
  localparam int          STA_SIF      = 7;
  localparam int          STA_OIF      = 6;
  localparam int          PIN_DO       = 0;
  localparam int          PIN_SDA      = 1;
  localparam int          PIN_SCL      = 2;
  localparam int          IRQ_START    = 0;
  localparam int          IRQ_OVF      = 1;
  localparam logic [3:0]  CNT_MAX      = 4'hf;
  localparam logic [7:0]  REG_RST      = 8'h00;

  typedef enum logic [1:0] {
    SWM_WM_OFF      = 2'b00,
    SWM_WM_THREE    = 2'b01,
    SWM_WM_TWO      = 2'b10,
    SWM_WM_TWO_HOLD = 2'b11
  } swm_wm_t;

endpackage : swm_pkg

// [test/swm_far_end.sv]
// Purpose: far-side line model for the serial pins
// Assumes: bus pull-ups on the data and clock lines
// Notes: an undriven data-out pin without pull-up shows a changing level
module swm_far_end
  import swm_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic [NPIN-1:0] pin_out,
  input  wire logic [NPIN-1:0] pin_oe,
  input  wire logic [NPIN-1:0] pin_pullup,
  input  wire logic [NPIN-1:0] drv_lo,
  output logic      [NPIN-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip = 1'b0;
  always @(posedge mclk) flip <= ~flip;
  // wired-and of both parties
  always_comb begin
    for (int b = 0; b < NPIN; b++) begin
      if (drv_lo[b] || (pin_oe[b] && !pin_out[b]))
        pin_in[b] = 1'b0;
      else if (pin_oe[b] || pin_pullup[b] || b != PIN_DO)
        pin_in[b] = 1'b1;
      else
        pin_in[b] = flip;
    end
  end
endmodule : swm_far_end

// [test/serial_interface_wire_mode_ctrl_test.sv]
// Purpose: self-checking bench for the wire mode controller
// Assumes: responses one cycle after a taken request
// Notes: link clock half period is 4 mclk cycles in scl_pulse, 6 in the two-wire and mode 11 steps
module serial_interface_wire_mode_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  import swm_pkg::*;
  logic              mclk  = 1'b0;
  logic              rst_n = 1'b0;
  logic              cyc   = 1'b0;
  logic              stb   = 1'b0;
  logic              we    = 1'b0;
  logic [ADDR_W-1:0] adr   = '0;
  logic [31:0]       dw    = '0;
  logic [NPIN-1:0]   lo    = '0;
  logic [31:0]       dr;
  logic              ack;
  logic              irq;
  logic [NPIN-1:0]   pout;
  logic [NPIN-1:0]   poe;
  logic [NPIN-1:0]   ppu;
  logic [NPIN-1:0]   pin;
  logic [7:0]        rd;
  logic [7:0]        byt;
  int                n_fail   = 0;
  int                compares = 0;

  always #20 mclk = ~mclk;

  swm_ctrl u_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .wb_cyc(cyc), .wb_stb(stb),
    .wb_we(we), .wb_adr(adr), .wb_sel(4'hf), .wb_dat_w(dw), .wb_dat_r(dr), .wb_ack(ack),
    .pin_in(pin), .pin_out(pout), .pin_oe(poe), .pin_pullup(ppu), .irq(irq));
  swm_far_end u_far (.mclk(mclk), .pin_out(pout), .pin_oe(poe), .pin_pullup(ppu),
    .drv_lo(lo), .pin_in(pin));

  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dw  <= {24'h0, d};
    for (i = 0; i < 20 && ack !== 1'b1; i++)
      @(posedge mclk);
    if (i == 20) begin
      n_fail++;
      final_report();
    end
    rd = dr[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask : wb

  task automatic scl_pulse(input logic sda);
    lo[PIN_SDA] <= ~sda;
    lo[PIN_SCL] <= 1'b1;
    tick(4);
    lo[PIN_SCL] <= 1'b0;
    tick(4);
  endtask : scl_pulse

  initial begin
    void'($urandom(32'h3d5c8e87));
    byt = 8'($urandom);
    tick(12);
    rst_n <= 1'b1;
    tick(4);
    for (int a = 0; a < 8; a++) begin
      wb(1'b0, 5'(a * 4), 8'h00);
      chk(rd, REG_RST);
    end
    wb(1'b1, OFF_PORT, 8'h05);
    wb(1'b1, OFF_DIR, 8'h03);
    tick(3);
    chk({2'h0, poe, pout & poe}, 8'h19);
    chk(8'(ppu), 8'h04);
    // three-wire: data bit opposite to port bit
    wb(1'b1, OFF_CTRL, 8'h10);
    wb(1'b1, OFF_DIR, 8'h07);
    wb(1'b1, OFF_PORT, {5'h0, 2'b11, ~byt[7]});
    wb(1'b1, OFF_DATA, byt);
    tick(3);
    chk(8'(pout), {5'h0, 2'b11, byt[7]});
    wb(1'b1, OFF_DIR, 8'h06);
    tick(3);
    chk(8'(ppu[PIN_DO]), {7'h0, ~byt[7]});
    wb(1'b1, OFF_CTRL, 8'h11);
    tick(3);
    chk(8'(pout[PIN_SCL]), 8'h00);
    // mode 00, external clock, byte from far master
    wb(1'b1, OFF_DIR, 8'h00);
    wb(1'b1, OFF_CTRL, 8'h08);
    tick(4);
    wb(1'b1, OFF_STAT, 8'hc0);
    wb(1'b1, OFF_IRQ_MASK, 8'h02);
    wb(1'b0, OFF_IRQ_STAT, 8'h00);
    for (int b = 7; b >= 0; b--)
      scl_pulse(byt[b]);
    lo <= '0;
    tick(4);
    wb(1'b0, OFF_DATA, 8'h00);
    chk(rd, byt);
    wb(1'b0, OFF_STAT, 8'h00);
    chk(rd, 8'hc0);
    chk(8'(irq), 8'h01);
    wb(1'b0, OFF_IRQ_STAT, 8'h00);
    chk(rd, 8'h03);
    tick(2);
    chk(8'(irq), 8'h00);
    wb(1'b1, OFF_IRQ_MASK, 8'h00);
    wb(1'b1, OFF_GIE, 8'h01);
    foreach (byt[k]) begin
      if (k < 4) begin
        wb(1'b1, OFF_CTRL, k[0] ? 8'h08 : (k[1] ? 8'h88 : 8'h48));
        tick(2);
        chk(8'(irq), 8'(!k[0]));
      end
    end
    wb(1'b1, OFF_GIE, 8'h00);
    wb(1'b1, OFF_STAT, 8'hc0);
    // two-wire: start detect and hold
    wb(1'b1, OFF_DATA, 8'h80);
    wb(1'b1, OFF_PORT, 8'h07);
    wb(1'b1, OFF_DIR, 8'h06);
    wb(1'b1, OFF_CTRL, 8'h20);
    tick(3);
    chk(8'({poe, ppu[2:1]}), 8'h00);
    lo[PIN_SDA] <= 1'b1;
    tick(6);
    lo[PIN_SCL] <= 1'b1;
    tick(6);
    lo[PIN_SCL] <= 1'b0;
    tick(6);
    chk(8'(poe[PIN_SCL]), 8'h01);
    wb(1'b0, OFF_STAT, 8'h00);
    chk(rd & 8'h80, 8'h80);
    wb(1'b1, OFF_STAT, 8'h80);
    tick(3);
    chk(8'(poe[PIN_SCL]), 8'h00);
    lo[PIN_SDA] <= 1'b0;
    tick(6);
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, OFF_DATA, {k[1], 7'h00});
      wb(1'b1, OFF_PORT, {5'h0, 1'b1, k[0], 1'b1});
      tick(3);
      chk(8'(poe[PIN_SDA]), 8'(!(k[1] && k[0])));
    end
    wb(1'b1, OFF_STAT, 8'h80);
    tick(3);
    chk(8'(poe[PIN_SCL]), 8'h00);
    wb(1'b1, OFF_PORT, 8'h03);
    tick(3);
    chk(8'(poe[PIN_SCL]), 8'h01);
    wb(1'b1, OFF_DIR, 8'h00);
    tick(3);
    chk(8'(poe), 8'h00);
    // mode 11: overflow hold
    wb(1'b1, OFF_PORT, 8'h07);
    wb(1'b1, OFF_DIR, 8'h04);
    wb(1'b1, OFF_CTRL, 8'h38);
    wb(1'b1, OFF_STAT, 8'hcf);
    lo[PIN_SCL] <= 1'b1;
    tick(6);
    lo[PIN_SCL] <= 1'b0;
    tick(6);
    chk(8'(poe[PIN_SCL]), 8'h01);
    wb(1'b1, OFF_STAT, 8'h40);
    tick(3);
    chk(8'(poe[PIN_SCL]), 8'h00);
    final_report();
  end

  initial begin
    tick(20000);
    n_fail++;
    final_report();
  end
endmodule : serial_interface_wire_mode_ctrl_test
